/* logic/cfg_device.sv */
// configuration loader and init sequencer, device end
`timescale 1ns/1ps
`include "cfg_load_defs.svh"
module cfg_device
	import cfg_load_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	cfg_link_if.device LINK,
	input wire cfg_mode_t MODE,
	input wire logic USR_CLK_OPT,
	input wire logic INIT_PIN_OPT,
	input wire logic [31:0] LOAD_WORDS,
	output logic [31:0] RX_WORD,
	output logic RX_VALID,
	output logic USER_MODE,
	output logic [2:0] STATE
);
	// ****************************************
	// synchronisers
	// ****************************************
	logic req_s1_q, req_s2_q, req_prev_q;
	logic cd_s1_q, cd_s2_q;
	logic usr_s1_q, usr_s2_q, usr_prev_q;
	logic stn_s1_q, stn_s2_q;
	dev_state_t state_q;
	always_ff @(posedge CLK) begin
		req_s1_q <= LINK.config_request_n;
		req_s2_q <= req_s1_q;
		req_prev_q <= req_s2_q;
		cd_s1_q <= LINK.load_complete;
		cd_s2_q <= cd_s1_q;
		usr_s1_q <= LINK.user_startup_clock;
		usr_s2_q <= usr_s1_q;
		usr_prev_q <= usr_s2_q;
		stn_s1_q <= LINK.config_status_n;
		stn_s2_q <= stn_s1_q;
	end
	wire req_fall = req_prev_q & ~req_s2_q;
	wire usr_rise = usr_s2_q & ~usr_prev_q;

	// ****************************************
	// link domain: data capture
	// ****************************************
	logic [31:0] word_q = 32'h0;
	logic [31:0] count_q = 32'h0;
	logic tog_q = 1'b0;
	logic [4:0] nib_q = 5'h0;
	logic arm_q;
	logic done_q = 1'b0;
	wire pull = (MODE == MODE_SERIAL_PULL);
	// arm_q is quasi-static: settles long before the first link clock edge
	wire push_edge_en = ~pull & arm_q & ~done_q;
	always_ff @(posedge LINK.config_clock) begin
		if (!arm_q) begin
			count_q <= 32'h0;
			done_q <= 1'b0;
			tog_q <= 1'b0;
		end else if (push_edge_en) begin
			word_q <= (MODE == MODE_PARALLEL_PUSH) ? LINK.config_data_bus :
				{word_q[30:0], LINK.config_data_bus[0]};
			count_q <= count_q + 32'h1;
			if (MODE == MODE_PARALLEL_PUSH || count_q[4:0] == 5'h1f) tog_q <= ~tog_q;
			if (MODE == MODE_PARALLEL_PUSH) begin
				if (count_q + 32'h1 >= LOAD_WORDS) done_q <= 1'b1;
			end else if (count_q[4:0] == 5'h1f && count_q[31:5] + 27'h1 >= LOAD_WORDS[26:0]) begin
				done_q <= 1'b1;
			end
		end
	end
	logic [31:0] pword_q = 32'h0;
	logic [31:0] pcount_q = 32'h0;
	logic ptog_q = 1'b0;
	logic pdone_q = 1'b0;
	logic cmd_q = 1'b0;
	always_ff @(negedge LINK.config_clock) begin
		if (!arm_q || !pull) begin
			pcount_q <= 32'h0;
			pdone_q <= 1'b0;
			ptog_q <= 1'b0;
			cmd_q <= 1'b0;
			nib_q <= 5'h0;
		end else if (!pdone_q) begin
			cmd_q <= ~cmd_q;
			pword_q <= {pword_q[27:0], LINK.serial_pull_data};
			nib_q <= nib_q + 5'h1;
			if (nib_q[2:0] == 3'h7) begin
				ptog_q <= ~ptog_q;
				pcount_q <= pcount_q + 32'h1;
				if (pcount_q + 32'h1 >= LOAD_WORDS) pdone_q <= 1'b1;
			end
		end
	end
	assign LINK.serial_pull_cmd_out = cmd_q;

	// ****************************************
	// crossing into CLK
	// ****************************************
	logic t_s1_q, t_s2_q, t_prev_q, d_s1_q, d_s2_q;
	always_ff @(posedge CLK) begin
		t_s1_q <= pull ? ptog_q : tog_q;
		t_s2_q <= t_s1_q;
		t_prev_q <= t_s2_q;
		d_s1_q <= pull ? pdone_q : done_q;
		d_s2_q <= d_s1_q;
	end
	always_ff @(posedge CLK) begin
		RX_VALID <= NRST & (state_q == DEV_LOAD) & (t_s2_q ^ t_prev_q);
		if (t_s2_q ^ t_prev_q) RX_WORD <= pull ? pword_q : word_q;
		if (!NRST) RX_WORD <= 32'h0;
	end

	// ****************************************
	// sequencer
	// ****************************************
	logic [31:0] tmr_q;
	logic st_low_q, cd_low_q, init_low_q;
	always_ff @(posedge CLK) begin
		arm_q <= NRST & (state_q == DEV_LOAD);
	end
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_q <= DEV_RESET;
			tmr_q <= 32'h0;
			st_low_q <= 1'b1;
			cd_low_q <= 1'b1;
			init_low_q <= 1'b0;
		end else if (req_fall) begin
			state_q <= DEV_STATUS_LOW;
			st_low_q <= 1'b1;
			cd_low_q <= 1'b1;
			init_low_q <= 1'b0;
			tmr_q <= 32'h0;
		end else begin
			tmr_q <= tmr_q + 32'h1;
			unique case (state_q)
				DEV_RESET: begin
					if (req_s2_q) begin
						state_q <= DEV_STATUS_LOW;
						tmr_q <= 32'h0;
					end
				end
				DEV_STATUS_LOW: begin
					if (tmr_q >= 32'(`STATUS_CYC) - 32'h1) begin
						state_q <= DEV_WAIT_REQ_HIGH;
					end
				end
				DEV_WAIT_REQ_HIGH: begin
					if (req_s2_q) begin
						st_low_q <= 1'b0;
						state_q <= DEV_LOAD;
					end
				end
				DEV_LOAD: begin
					if (d_s2_q) begin
						cd_low_q <= 1'b0;
						init_low_q <= INIT_PIN_OPT;
						state_q <= USR_CLK_OPT ? DEV_CU_WAIT : DEV_INIT;
						tmr_q <= 32'h0;
					end
				end
				DEV_CU_WAIT: begin
					if (cd_s2_q && tmr_q >= 32'(`CU_EN_PERIODS * `CLKDIV * 2)) begin
						state_q <= DEV_INIT;
						tmr_q <= 32'h0;
					end
				end
				DEV_INIT: begin
					if (USR_CLK_OPT) begin
						tmr_q <= tmr_q + {31'h0, usr_rise};
						if (tmr_q >= 32'(`USR_INIT_CYCLES)) begin
							state_q <= DEV_USER;
							init_low_q <= 1'b0;
						end
					end else if (tmr_q >= 32'(`UM_CYC)) begin
						state_q <= DEV_USER;
						init_low_q <= 1'b0;
					end
				end
				DEV_USER: begin
					init_low_q <= 1'b0;
				end
			endcase
		end
	end
	assign LINK.status_dev_low = st_low_q;
	assign LINK.load_complete_low = cd_low_q;
	assign LINK.init_finished = ~init_low_q;
	assign USER_MODE = (state_q == DEV_USER) & stn_s2_q;
	assign STATE = state_q;
endmodule : cfg_device

/* logic/cfg_host.sv */
// configuration host end
`timescale 1ns/1ps
`include "cfg_load_defs.svh"
module cfg_host
	import cfg_load_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	cfg_link_if.host LINK,
	input wire cfg_mode_t MODE,
	input wire logic START,
	input wire logic [31:0] DATA_IN,
	output logic DATA_READY,
	input wire logic DATA_VALID,
	output logic BUSY,
	output logic DONE
);
	logic st_s1_q, st_s2_q, cd_s1_q, cd_s2_q;
	always_ff @(posedge CLK) begin
		st_s1_q <= LINK.config_status_n;
		st_s2_q <= st_s1_q;
		cd_s1_q <= LINK.load_complete;
		cd_s2_q <= cd_s1_q;
	end
	host_state_t state_q;
	logic [31:0] tmr_q;
	logic req_n_q, clk_q, usr_q;
	logic [31:0] data_q;
	logic [4:0] bit_q;
	logic have_q;
	logic adv_q;
	always_ff @(posedge CLK) begin
		if (!NRST) usr_q <= 1'b0;
		else usr_q <= ~usr_q;
	end
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_q <= HOST_IDLE;
			tmr_q <= 32'h0;
			req_n_q <= 1'b1;
			clk_q <= 1'b0;
			data_q <= 32'h0;
			bit_q <= 5'h0;
			have_q <= 1'b0;
			adv_q <= 1'b0;
		end else begin
			tmr_q <= tmr_q + 32'h1;
			unique case (state_q)
				HOST_IDLE: begin
					if (START) begin
						state_q <= HOST_REQ_LOW;
						req_n_q <= 1'b0;
						tmr_q <= 32'h0;
					end
				end
				HOST_REQ_LOW: begin
					if (tmr_q >= 32'(`REQ_LOW_CYC)) begin
						req_n_q <= 1'b1;
						state_q <= HOST_WAIT_STATUS;
					end
				end
				HOST_WAIT_STATUS: begin
					tmr_q <= 32'h0;
					if (st_s2_q) state_q <= HOST_GAP;
				end
				HOST_GAP: begin
					if (tmr_q >= 32'(`ST2CK_CYC)) state_q <= HOST_SEND;
					tmr_q <= (tmr_q >= 32'(`ST2CK_CYC)) ? 32'h0 : tmr_q + 32'h1;
				end
				HOST_SEND: begin
					if (tmr_q >= 32'(`CLKDIV - 1)) begin
						tmr_q <= 32'h0;
						if (clk_q) begin
							clk_q <= 1'b0;
							adv_q <= (MODE == MODE_SERIAL_PULL);
						end else if (have_q) begin
							clk_q <= 1'b1;
							adv_q <= (MODE != MODE_SERIAL_PULL);
						end
						if (cd_s2_q) state_q <= HOST_CLK_TAIL;
					end
					// data moves one cycle after the capturing edge, never on it
					if (adv_q) begin
						adv_q <= 1'b0;
						bit_q <= bit_q + 5'h1;
						if (MODE == MODE_PARALLEL_PUSH ||
							(MODE == MODE_SERIAL_PULL ? bit_q[2:0] == 3'h7 : bit_q == 5'h1f)) begin
							have_q <= 1'b0;
						end else if (MODE == MODE_SERIAL_PULL) begin
							data_q <= {data_q[27:0], 4'h0};
						end else begin
							data_q <= {data_q[30:0], 1'b0};
						end
					end
					if (DATA_VALID && DATA_READY) begin
						data_q <= DATA_IN;
						have_q <= 1'b1;
						bit_q <= 5'h0;
					end
				end
				HOST_CLK_TAIL: begin
					if (tmr_q >= 32'(`CLKDIV - 1)) begin
						tmr_q <= 32'h0;
						clk_q <= ~clk_q;
						if (bit_q == 5'h1f) state_q <= HOST_DONE;
						if (clk_q) bit_q <= bit_q + 5'h1;
					end
				end
				HOST_DONE: begin
					clk_q <= 1'b0;
					if (!st_s2_q) state_q <= HOST_IDLE;
				end
			endcase
		end
	end
	assign DATA_READY = (state_q == HOST_SEND) & ~have_q;
	assign LINK.config_request_n = req_n_q;
	assign LINK.status_host_low = 1'b0;
	assign LINK.config_clock = clk_q;
	assign LINK.config_data_bus = (MODE == MODE_PARALLEL_PUSH) ? data_q : {31'h0, data_q[31]};
	assign LINK.serial_pull_data = data_q[31:28];
	assign LINK.user_startup_clock = usr_q;
	assign BUSY = (state_q != HOST_IDLE) & (state_q != HOST_DONE);
	assign DONE = (state_q == HOST_DONE);
endmodule : cfg_host

/* logic/cfg_link_if.sv */
// link between configuration host and device
`timescale 1ns/1ps
interface cfg_link_if;
	logic config_request_n;
	logic status_dev_low;
	logic status_host_low;
	logic config_status_n;
	logic load_complete_low;
	logic load_complete;
	logic config_clock;
	logic [31:0] config_data_bus;
	logic [3:0] serial_pull_data;
	logic serial_pull_cmd_out;
	logic user_startup_clock;
	logic init_finished;
	assign config_status_n = ~(status_dev_low | status_host_low);
	assign load_complete = ~load_complete_low;
	modport device (
		input config_request_n, config_status_n, config_clock, config_data_bus,
		input serial_pull_data, user_startup_clock, load_complete,
		output status_dev_low, load_complete_low, serial_pull_cmd_out, init_finished
	);
	modport host (
		input config_status_n, load_complete, serial_pull_cmd_out, init_finished,
		output config_request_n, status_host_low, config_clock, config_data_bus,
		output serial_pull_data, user_startup_clock
	);
endinterface : cfg_link_if

/* logic/cfg_load_defs.svh */
// constants for the configuration load and init sequencer
// Summary of operation
// - four-lane pull mode moves four bits per clock
// - init clock in any mode: oscillator or startup pin
// - init_finished low once enabled until init done
// - request fall pulls status and complete low fast
// - host holds request low at least 2 us
// - status stays low 268 to 1506 us
// - status released within 1506 us of request rise
// - host waits after status rise before clocking
// - push data captured on rising config clock
// - pull mode launches and captures on falling edge
// - oscillator init: user mode 175 to 437 us
// - startup clock enabled after four clock periods
// - startup clock init needs 8576 extra cycles
// - startup clock used only when option set
`ifndef CFG_LOAD_DEFS_SVH
`define CFG_LOAD_DEFS_SVH
`define CLK_MHZ 25
`define REQ_LOW_MIN_NS 2000
`define REQ_LOW_CYC ((`REQ_LOW_MIN_NS * `CLK_MHZ + 999) / 1000)
`define FALL_MAX_NS 600
`define FALL_CYC ((`FALL_MAX_NS * `CLK_MHZ) / 1000)
`define STATUS_MIN_US 268
`define STATUS_MAX_US 1506
`define STATUS_CYC ((`STATUS_MIN_US + `STATUS_MAX_US) / 2 * `CLK_MHZ)
`define ST2CK_US 2
`define ST2CK_CYC (`ST2CK_US * `CLK_MHZ)
`define UM_MIN_US 175
`define UM_MAX_US 437
`define UM_CYC ((`UM_MIN_US + `UM_MAX_US) / 2 * `CLK_MHZ)
`define CU_EN_PERIODS 4
`define USR_INIT_CYCLES 8576
`define OSC_MAX_KHZ 12500
`define USR_MAX_MHZ 125
`define WORD_W 32
`define LANES 4
`define CLKDIV 2
`endif

/* logic/cfg_load_pkg.sv */
// types for the configuration load and init sequencer
package cfg_load_pkg;
	typedef enum logic [1:0] {
		MODE_SERIAL_PUSH,
		MODE_PARALLEL_PUSH,
		MODE_SERIAL_PULL
	} cfg_mode_t;
	typedef enum logic [2:0] {
		DEV_RESET,
		DEV_STATUS_LOW,
		DEV_WAIT_REQ_HIGH,
		DEV_LOAD,
		DEV_CU_WAIT,
		DEV_INIT,
		DEV_USER
	} dev_state_t;
	typedef enum logic [2:0] {
		HOST_IDLE,
		HOST_REQ_LOW,
		HOST_WAIT_STATUS,
		HOST_GAP,
		HOST_SEND,
		HOST_CLK_TAIL,
		HOST_DONE
	} host_state_t;
endpackage : cfg_load_pkg

/* verification/cfg_link_checker.sv */
// assertions on the link between host and device
`timescale 1ns/1ps
module cfg_link_checker (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic config_request_n,
	input wire logic config_status_n,
	input wire logic status_dev_low,
	input wire logic load_complete,
	input wire logic config_clock,
	input wire logic [31:0] config_data_bus,
	input wire logic init_finished
);
	localparam int MIN_ST = 6700;
	localparam int MAX_ST = 37650;
	int req_q;
	int st_q;
	int cf_q;
	int hi_q;
	int cd_q;
	logic prev_q;
	logic arm_q;
	wire fall = prev_q & ~config_request_n;
	// ****************
	// helper counters
	// ****************
	always_ff @(posedge CLK) prev_q <= !NRST | config_request_n;
	always_ff @(posedge CLK) arm_q <= NRST & (arm_q | fall);
	always_ff @(posedge CLK) req_q <= (!NRST || config_request_n) ? 0 : req_q + 1;
	always_ff @(posedge CLK) st_q <= (!NRST || fall) ? 0 : st_q + int'(status_dev_low);
	always_ff @(posedge CLK) cf_q <= (!NRST || !config_request_n || !status_dev_low) ? 0 : cf_q + 1;
	always_ff @(posedge CLK) hi_q <= (!NRST || !config_status_n) ? 0 : hi_q + 1;
	always_ff @(posedge CLK) cd_q <= (!NRST || !load_complete) ? 0 : cd_q + 1;
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	property p_fall;
		$fell(config_request_n) |-> ##[1:15] (!config_status_n && !load_complete);
	endproperty
	a_fall: assert property (p_fall) else $error("restart not seen");
	property p_req;
		$rose(config_request_n) |-> req_q >= 50;
	endproperty
	a_req: assert property (p_req) else $error("request pulse short");
	property p_st;
		$fell(status_dev_low) && arm_q |-> st_q >= MIN_ST && st_q <= MAX_ST;
	endproperty
	a_st: assert property (p_st) else $error("status pulse width");
	property p_rel;
		cf_q <= MAX_ST;
	endproperty
	a_rel: assert property (p_rel) else $error("status release late");
	property p_gap;
		$rose(config_clock) |-> hi_q >= 50;
	endproperty
	a_gap: assert property (p_gap) else $error("clock too soon");
	property p_data;
		$rose(config_clock) |-> $stable(config_data_bus);
	endproperty
	a_data: assert property (p_data) else $error("data moved at edge");
	property p_init;
		$rose(load_complete) |-> !init_finished [*8];
	endproperty
	a_init: assert property (p_init) else $error("init flag early");
	property p_um;
		$rose(init_finished) && load_complete |-> cd_q >= 4375;
	endproperty
	a_um: assert property (p_um) else $error("user mode early");
	cover property ($rose(load_complete));
	cover property ($rose(init_finished));
	cover property ($fell(status_dev_low) && arm_q);
endmodule : cfg_link_checker

/* verification/test_config_load_init_sequencer.sv */
// self-checking bench for host and device ends
`timescale 1ns/1ps
module test_config_load_init_sequencer;
	import cfg_load_pkg::*;
	localparam int NW = 3;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	cfg_mode_t mode = MODE_SERIAL_PUSH;
	logic usr_opt = 1'b0;
	logic start = 1'b0;
	logic data_valid = 1'b0;
	logic [31:0] data_in = 32'h0;
	logic take = 1'b0;
	logic [31:0] rx_word;
	logic rx_valid;
	logic user_mode;
	logic data_ready;
	int error_cnt = 0;
	int total_checks = 0;
	int rx_cnt = 0;
	int idx = 0;
	int uc_cnt = 0;
	int cyc = 0;
	cfg_link_if link ();
	always #20 clk = ~clk;
	// ****************
	// ends and checker
	// ****************
	cfg_host cfg_host_i (.CLK(clk), .NRST(nrst), .LINK(link.host), .MODE(mode),
		.START(start), .DATA_IN(data_in), .DATA_READY(data_ready),
		.DATA_VALID(data_valid), .BUSY(), .DONE());
	cfg_device cfg_device_i (.CLK(clk), .NRST(nrst), .LINK(link.device), .MODE(mode),
		.USR_CLK_OPT(usr_opt), .INIT_PIN_OPT(1'b1), .LOAD_WORDS(32'h3),
		.RX_WORD(rx_word), .RX_VALID(rx_valid), .USER_MODE(user_mode), .STATE());
	cfg_link_checker cfg_link_checker_i (.CLK(clk), .NRST(nrst),
		.config_request_n(link.config_request_n), .config_status_n(link.config_status_n),
		.status_dev_low(link.status_dev_low), .load_complete(link.load_complete),
		.config_clock(link.config_clock), .config_data_bus(link.config_data_bus),
		.init_finished(link.init_finished));
	// ****************
	// tasks and traffic
	// ****************
	function automatic logic [31:0] word_at(int k);
		return 32'h9e37_79b9 ^ (32'h0f1e_2d3c << k);
	endfunction : word_at
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	always @(posedge link.user_startup_clock) uc_cnt++;
	always @(negedge clk) begin
		take = data_valid && data_ready;
		if (rx_valid === 1'b1) begin
			check("rx_word", rx_word, word_at(rx_cnt));
			rx_cnt++;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (take) begin
			idx <= idx + 1;
			data_in <= word_at(idx + 1);
			data_valid <= 1'(idx + 1 < NW);
		end
		if (cyc == 99000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic run(cfg_mode_t m, logic uo, logic full);
		int t;
		@(posedge clk);
		nrst <= 1'b0;
		mode <= m;
		usr_opt <= uo;
		idx <= 0;
		data_in <= word_at(0);
		data_valid <= 1'b1;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rx_cnt = 0;
		repeat (2) @(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (t = 0; t < 60000 && link.load_complete !== 1'b1; t++) @(negedge clk);
		uc_cnt = 0;
		repeat (4) @(posedge clk);
		check("load_complete", 32'(link.load_complete), 32'h1);
		check("words", 32'(rx_cnt), 32'(NW));
		if (full) begin
			for (t = 0; t < 60000 && user_mode !== 1'b1; t++) @(negedge clk);
			if (uo) check("startup clocks", 32'(uc_cnt >= 8576), 32'h1);
			else check("init time", 32'(t >= 4375 && t <= 10925), 32'h1);
			check("init_finished", 32'(link.init_finished), 32'h1);
		end
		$display("test mode %0d startup %0d ended", m, uo);
	endtask : run
	initial begin
		run(MODE_SERIAL_PUSH, 1'b0, 1'b0);
		run(MODE_SERIAL_PULL, 1'b0, 1'b1);
		run(MODE_PARALLEL_PUSH, 1'b1, 1'b1);
		conclude();
	end
endmodule : test_config_load_init_sequencer
